// ### hw/cpcd_pkg.sv
// shared constants and types for the configuration port command decoder
// assumes a single configuration clock at 10 MHz and an 8-bit host data port
package cpcd_pkg;

  // data port and configuration array geometry
  localparam int DATA_W = 8;
  localparam int ROW_BYTES = 4;
  localparam int NUM_ROWS = 16;
  localparam int ROW_AW = 4;
  localparam int ROW_IW = 2;
  localparam int ID_BYTES = 4;
  localparam int BIDX_W = 3;
  localparam int CMD_W = 4;

  // command codes in the low nibble of the command register
  localparam logic [CMD_W-1:0] CMD_NOP = 4'h0;
  localparam logic [CMD_W-1:0] CMD_RESET_DEV = 4'h1;
  localparam logic [CMD_W-1:0] CMD_LOAD_CFG = 4'h2;
  localparam logic [CMD_W-1:0] CMD_RESET_ROW = 4'h3;
  localparam logic [CMD_W-1:0] CMD_LOAD_ROW = 4'h4;
  localparam logic [CMD_W-1:0] CMD_READ_ROW = 4'h5;
  localparam logic [CMD_W-1:0] CMD_READ_ID = 4'h6;

  // status register bit positions
  localparam int STAT_ID_ERR = 0;
  localparam int STAT_CHK_ERR = 1;
  localparam int STAT_BUSY = 2;

  // byte index limits
  localparam logic [BIDX_W-1:0] BIDX_ZERO = 3'h0;
  localparam logic [BIDX_W-1:0] BIDX_CHK = 3'(ROW_BYTES);
  localparam logic [BIDX_W-1:0] BIDX_ROW_LAST = 3'(ROW_BYTES - 1);
  localparam logic [BIDX_W-1:0] BIDX_ID_LAST = 3'(ID_BYTES - 1);
  localparam logic [ROW_AW-1:0] ROW_FIRST = 4'h0;
  localparam logic [ROW_AW-1:0] ROW_LAST = 4'(NUM_ROWS - 1);

  // internal row operation time
  localparam int CLK_NS = 100;
  localparam int ROW_OP_NS = 400;
  localparam int ROW_OP_CYC_RAW = (ROW_OP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ROW_OP_CYC = (ROW_OP_CYC_RAW < 1) ? 1 : ROW_OP_CYC_RAW;
  localparam int OPC_W = 4;
  localparam logic [OPC_W-1:0] OPC_LAST = 4'(ROW_OP_CYC - 1);

  typedef logic [DATA_W-1:0] cpcd_byte_t;
  typedef cpcd_byte_t [ROW_BYTES-1:0] cpcd_row_t;

  // host pins as sampled together
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic rs;
    cpcd_byte_t data;
  } cpcd_host_t;

  // internal array operations
  typedef enum logic [1:0] {
    MOP_CLR_ALL,
    MOP_CLR_ROW,
    MOP_WRITE,
    MOP_READ
  } cpcd_mop_t;

endpackage

// ### hw/cpcd_row_mem.sv
// configuration row array with timed clear, write and read operations
// assumes op_start is a one-cycle pulse and is not raised while busy
`timescale 1ns/1ns
`default_nettype none
module cpcd_row_mem
  import cpcd_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // operation request
  input wire logic op_start,
  input wire cpcd_mop_t op,
  input wire logic [ROW_AW-1:0] row_addr,
  input wire cpcd_row_t wr_row,
  // results
  output cpcd_row_t rd_row,
  output logic op_done
);

  cpcd_row_t mem [NUM_ROWS];
  logic active_reg;
  cpcd_mop_t op_reg;
  logic [ROW_AW-1:0] addr_reg;
  cpcd_row_t data_reg;
  logic [OPC_W-1:0] cnt_reg;

  // end of operation decode
  wire logic is_clr_all = (op_reg == MOP_CLR_ALL);
  wire logic finish = active_reg && (is_clr_all ? (addr_reg == ROW_LAST) : (cnt_reg == OPC_LAST));
  wire logic mem_we = active_reg && (is_clr_all || (finish && op_reg != MOP_READ));
  wire cpcd_row_t mem_wdata = (op_reg == MOP_WRITE) ? data_reg : '0;

  // operation sequencing
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      active_reg <= 1'b0;
      op_reg <= MOP_CLR_ALL;
      addr_reg <= ROW_FIRST;
      data_reg <= '0;
      cnt_reg <= '0;
      op_done <= 1'b0;
    end
    else
    begin
      op_done <= finish;
      if (op_start && !active_reg)
      begin
        active_reg <= 1'b1;
        op_reg <= op;
        addr_reg <= (op == MOP_CLR_ALL) ? ROW_FIRST : row_addr;
        data_reg <= wr_row;
        cnt_reg <= '0;
      end
      else if (active_reg)
      begin
        cnt_reg <= cnt_reg + 4'h1;
        if (is_clr_all && !finish)
          addr_reg <= addr_reg + 4'h1;
        if (finish)
          active_reg <= 1'b0;
      end
    end
  end

  // array storage and fetch
  always_ff @(posedge mclk)
  begin
    if (mem_we)
      mem[addr_reg] <= mem_wdata;
    if (!reset_n)
      rd_row <= '0;
    else if (finish && op_reg == MOP_READ)
      rd_row <= mem[addr_reg];
  end

endmodule
`default_nettype wire

// ### hw/cpcd_decoder.sv
// command decoder for the asynchronous processor configuration port
// assumes host strobes are held at least three mclk periods and data is stable while a strobe is low
//
// Behaviour
// [RULE1] command 0000 does nothing and leaves the device in normal operation
// [RULE2] command 0001 clears the whole configuration, busy held until done
// [RULE3] command 0010 takes a full configuration bytewise, header block first
// [RULE4] data reads during a full load return the status register
// [RULE5] each complete row plus check byte is written with busy high
// [RULE6] host reads status after each busy fall during a full load
// [RULE7] after a load error further data writes are ignored until reset or 0010
// [RULE8] command 0011 takes the next data write as row address, clears that row
// [RULE9] row clear busy rises after the address and falls on completion
// [RULE10] command 0100 takes row address, then row bytes ending with check byte
// [RULE11] single row load raises busy after the check byte until written
// [RULE12] data reads during single row load return the status register
// [RULE13] command 0101 takes a row address and holds busy while fetching it
// [RULE14] after fetch, data reads return the row bytes without check byte
// [RULE15] readback order equals load order, rightmost byte first
// [RULE16] command 0110 makes four data reads return the identifier, high byte first
// [RULE17] register select low picks the command register, high the data/status
// [RULE18] busy is high whenever the device cannot accept data; here busy stays low while data writes are locked after an error
// [RULE19] status bit 0 wrong identifier, bit 1 check mismatch, bit 2 busy
// [RULE20] host never writes 0111 or codes with bit 3 set
// [RULE21] host strobes are synchronised so each access acts exactly once
// [RULE22] a new command abandons any partial sequence and restarts byte counting
`timescale 1ns/1ns
`default_nettype none
module cpcd_decoder
  import cpcd_pkg::*;
#(
  parameter logic [31:0] DEVICE_ID = 32'h5a3c_0e71 // arbitrary value
)
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // host bus pins
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic register_select_line,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe_n,
  output logic busy
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_CLR_ALL, ST_LD_HDR, ST_LD_DATA, ST_LD_WAIT,
    ST_CR_ADDR, ST_CR_WAIT, ST_LR_ADDR, ST_LR_DATA, ST_LR_WAIT,
    ST_RR_ADDR, ST_RR_WAIT, ST_RR_DATA, ST_ID
  } cpcd_state_t;

  // identifier byte, most significant first
  function automatic cpcd_byte_t id_byte(input logic [BIDX_W-1:0] idx);
    id_byte = cpcd_byte_t'(DEVICE_ID >> (DATA_W * (ID_BYTES - 1 - int'(idx))));
  endfunction

  cpcd_host_t s1_reg, s2_reg, s3_reg;
  cpcd_state_t state_reg, state_next;
  logic [BIDX_W-1:0] bidx_reg, bidx_next;
  logic [ROW_AW-1:0] row_reg, row_next;
  cpcd_row_t buf_reg, buf_next;
  cpcd_byte_t chk_reg, chk_next;
  logic id_err_reg, id_err_next, chk_err_reg, chk_err_next;
  logic mop_start_reg, mop_start_next;
  cpcd_mop_t mop_reg, mop_next;
  cpcd_row_t mem_rd_row;
  logic mop_done;

  ////////////////////////////////////////////////////////////////////////////
  // host pin synchroniser, s1 feeds only s2
  // [RULE21] three-stage sync
  always_ff @(posedge mclk)
  begin
    s1_reg <= {cs_n, rd_n, wr_n, register_select_line, data_in};
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
  end

  // strobe end detection, one pulse per write and per data-register read
  // [RULE17] register select decode
  wire logic wr_end = !s3_reg.wr_n && s2_reg.wr_n && !s3_reg.cs_n;
  wire logic rd_end = !s3_reg.rd_n && s2_reg.rd_n && !s3_reg.cs_n && s3_reg.rs;
  wire logic cmd_wr = wr_end && !s3_reg.rs;
  wire logic data_wr = wr_end && s3_reg.rs;
  wire logic [CMD_W-1:0] code = s3_reg.data[CMD_W-1:0];
  wire cpcd_byte_t wbyte = s3_reg.data;
  // [RULE7] lock data writes after an error
  wire logic err_lock = id_err_reg || chk_err_reg;
  wire logic cmd_ok = cmd_wr && !busy;
  wire logic dat_ok = data_wr && !busy && !err_lock;
  wire logic in_row_data = (state_reg == ST_LD_DATA) || (state_reg == ST_LR_DATA);

  ////////////////////////////////////////////////////////////////////////////
  // command and sequence state machine
  always_comb
  begin
    state_next = state_reg;
    bidx_next = bidx_reg;
    row_next = row_reg;
    buf_next = buf_reg;
    chk_next = chk_reg;
    id_err_next = id_err_reg;
    chk_err_next = chk_err_reg;
    mop_start_next = 1'b0;
    mop_next = mop_reg;
    if (cmd_ok)
    begin
      // [RULE22] restart byte counting
      bidx_next = BIDX_ZERO;
      chk_next = '0;
      case (code)
        // [RULE1] no operation
        CMD_NOP: state_next = ST_IDLE;
        // [RULE2] clear whole array
        CMD_RESET_DEV:
        begin
          state_next = ST_CLR_ALL;
          mop_next = MOP_CLR_ALL;
          mop_start_next = 1'b1;
          id_err_next = 1'b0;
          chk_err_next = 1'b0;
        end
        // [RULE3] full load starts at header
        CMD_LOAD_CFG:
        begin
          state_next = ST_LD_HDR;
          row_next = ROW_FIRST;
          id_err_next = 1'b0;
          chk_err_next = 1'b0;
        end
        CMD_RESET_ROW: state_next = ST_CR_ADDR;
        CMD_LOAD_ROW: state_next = ST_LR_ADDR;
        CMD_READ_ROW: state_next = ST_RR_ADDR;
        CMD_READ_ID: state_next = ST_ID;
        default: state_next = state_reg;
      endcase
    end
    else
    begin
      case (state_reg)
        // [RULE3] header identifier check
        ST_LD_HDR:
          if (dat_ok)
          begin
            if (wbyte != id_byte(bidx_reg))
              id_err_next = 1'b1;
            bidx_next = (bidx_reg == BIDX_ID_LAST) ? BIDX_ZERO : bidx_reg + 3'h1;
            if (bidx_reg == BIDX_ID_LAST)
              state_next = ST_LD_DATA;
          end
        // [RULE10] row bytes then check byte
        ST_LD_DATA, ST_LR_DATA:
          if (dat_ok)
          begin
            if (bidx_reg == BIDX_CHK)
            begin
              bidx_next = BIDX_ZERO;
              chk_next = '0;
              if (wbyte != chk_reg)
                chk_err_next = 1'b1;
              else
              begin
                // [RULE5] row copy into array
                mop_next = MOP_WRITE;
                mop_start_next = 1'b1;
                state_next = (state_reg == ST_LD_DATA) ? ST_LD_WAIT : ST_LR_WAIT;
              end
            end
            else
            begin
              buf_next[bidx_reg[ROW_IW-1:0]] = wbyte;
              chk_next = chk_reg ^ wbyte;
              bidx_next = bidx_reg + 3'h1;
            end
          end
        ST_LD_WAIT:
          if (mop_done)
          begin
            state_next = (row_reg == ROW_LAST) ? ST_IDLE : ST_LD_DATA;
            row_next = row_reg + 4'h1;
          end
        // [RULE8] row address capture
        ST_CR_ADDR, ST_LR_ADDR, ST_RR_ADDR:
          if (dat_ok)
          begin
            row_next = wbyte[ROW_AW-1:0];
            mop_start_next = (state_reg != ST_LR_ADDR);
            mop_next = (state_reg == ST_CR_ADDR) ? MOP_CLR_ROW : MOP_READ;
            case (state_reg)
              ST_CR_ADDR: state_next = ST_CR_WAIT;
              ST_LR_ADDR: state_next = ST_LR_DATA;
              default: state_next = ST_RR_WAIT;
            endcase
          end
        ST_CLR_ALL, ST_CR_WAIT, ST_LR_WAIT:
          if (mop_done)
            state_next = ST_IDLE;
        // [RULE13] fetched row lands in buffer
        ST_RR_WAIT:
          if (mop_done)
          begin
            buf_next = mem_rd_row;
            bidx_next = BIDX_ZERO;
            state_next = ST_RR_DATA;
          end
        // [RULE14] only data bytes, then done
        ST_RR_DATA:
          if (rd_end)
          begin
            bidx_next = bidx_reg + 3'h1;
            if (bidx_reg == BIDX_ROW_LAST)
              state_next = ST_IDLE;
          end
        // [RULE16] four identifier reads
        ST_ID:
          if (rd_end)
          begin
            bidx_next = bidx_reg + 3'h1;
            if (bidx_reg == BIDX_ID_LAST)
              state_next = ST_IDLE;
          end
        default: state_next = ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // busy and read data selection
  // [RULE18] [RULE9] [RULE11] busy during array operations
  wire logic busy_next = (state_next == ST_CLR_ALL) || (state_next == ST_LD_WAIT) ||
    (state_next == ST_CR_WAIT) || (state_next == ST_LR_WAIT) || (state_next == ST_RR_WAIT);
  // [RULE19] status layout
  wire cpcd_byte_t status = (cpcd_byte_t'(busy) << STAT_BUSY) | (cpcd_byte_t'(chk_err_reg) << STAT_CHK_ERR) |
    (cpcd_byte_t'(id_err_reg) << STAT_ID_ERR);
  // [RULE15] rightmost byte first
  wire cpcd_byte_t row_byte = buf_reg[bidx_reg[ROW_IW-1:0]];
  // [RULE4] [RULE12] status unless readback or identifier
  wire cpcd_byte_t dsel = (state_reg == ST_RR_DATA) ? row_byte :
    (state_reg == ST_ID) ? id_byte(bidx_reg) : status;
  wire cpcd_byte_t dout_next = s2_reg.rs ? dsel : 8'h00;
  wire logic oe_n_next = s2_reg.rd_n || s2_reg.cs_n;

  // state registers
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      state_reg <= ST_IDLE;
      bidx_reg <= BIDX_ZERO;
      row_reg <= ROW_FIRST;
      buf_reg <= '0;
      chk_reg <= '0;
      id_err_reg <= 1'b0;
      chk_err_reg <= 1'b0;
      mop_start_reg <= 1'b0;
      mop_reg <= MOP_CLR_ALL;
      busy <= 1'b0;
      data_out <= 8'h00;
      data_oe_n <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      bidx_reg <= bidx_next;
      row_reg <= row_next;
      buf_reg <= buf_next;
      chk_reg <= chk_next;
      id_err_reg <= id_err_next;
      chk_err_reg <= chk_err_next;
      mop_start_reg <= mop_start_next;
      mop_reg <= mop_next;
      busy <= busy_next;
      data_out <= dout_next;
      data_oe_n <= oe_n_next;
    end
  end

  // configuration array
  cpcd_row_mem u_row_mem (
    .mclk(mclk),
    .reset_n(reset_n),
    .op_start(mop_start_reg),
    .op(mop_reg),
    .row_addr(row_reg),
    .wr_row(buf_reg),
    .rd_row(mem_rd_row),
    .op_done(mop_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_nop_idle: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE1]
    cmd_ok && code == CMD_NOP |=> state_reg == ST_IDLE && !busy)
    else $error("nop command did not return to idle");
  a_clear_busy: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE2]
    cmd_ok && code == CMD_RESET_DEV |=> busy [*8])
    else $error("busy not held during device clear");
  a_load_status: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE4]
    (state_reg == ST_LD_DATA || state_reg == ST_LD_HDR) && s2_reg.rs |=> data_out == $past(status))
    else $error("load read did not return status");
  a_row_write: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE5]
    dat_ok && in_row_data && bidx_reg == BIDX_CHK && wbyte == chk_reg |=> busy ##1 mop_start_reg == 1'b0)
    else $error("row write not started with busy");
  a_lock_ignore: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE7]
    err_lock && data_wr && !cmd_wr |=> $stable(bidx_reg) && $stable(row_reg))
    else $error("data write taken while locked");
  a_clr_row_bound: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE9]
    state_reg == ST_CR_ADDR && dat_ok |=> busy ##[1:8] !busy)
    else $error("row clear busy not bounded");
  a_id_first: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE16]
    state_reg == ST_ID && bidx_reg == BIDX_ZERO && s2_reg.rs |=> data_out == DEVICE_ID[31:24])
    else $error("identifier high byte not first");
  a_cmd_restart: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE22]
    cmd_ok && code == CMD_LOAD_CFG |=> state_reg == ST_LD_HDR && bidx_reg == BIDX_ZERO && !err_lock)
    else $error("load command did not restart sequence");
  a_write_once: assert property (@(posedge mclk) disable iff (!reset_n) // [RULE21]
    wr_end |=> !wr_end)
    else $error("write strobe acted on twice");

endmodule
`default_nettype wire

// ### tb/cpcd_host_model.sv
// host processor model for the asynchronous configuration port
// assumes mclk is the device clock; pins change at its falling edge only
`timescale 1ns/1ns
`default_nettype none
module cpcd_host_model
  import cpcd_pkg::*;
(
  // clock
  input wire logic mclk,
  // host pins
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic rs,
  output cpcd_byte_t drv,
  output logic drv_en
);
  // idle pins from time zero
  initial
  begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    rs = 1'b0;
    drv = 8'h00;
    drv_en = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one access; select and data held over the whole strobe and after it
  // select chooses register
  task automatic access(input logic wr, input logic sel, input cpcd_byte_t d);
    @(negedge mclk);
    cs_n = 1'b0;
    rs = sel;
    drv = d;
    drv_en = wr;
    @(negedge mclk);
    wr_n = ~wr;
    rd_n = wr;
    repeat (5) @(negedge mclk);
    wr_n = 1'b1;
    rd_n = 1'b1;
    repeat (4) @(negedge mclk);
    cs_n = 1'b1;
    drv_en = 1'b0;
    drv = ~d; // released lines show no stale value
    repeat (3) @(negedge mclk);
  endtask
endmodule
`default_nettype wire

// ### tb/config_port_command_decoder_test.sv
// self-checking bench for the configuration port command decoder
// assumes the host model drives the pins; reads are checked off a queue
`timescale 1ns/1ns
`default_nettype none
module config_port_command_decoder_test
  import cpcd_pkg::*;
  ;
  localparam logic [31:0] TB_ID = 32'h1357_9bdf; // arbitrary value
  logic mclk;
  logic reset_n;
  logic cs_n, rd_n, wr_n, rs, drv_en, data_oe_n, busy, busy_seen;
  cpcd_byte_t drv, data_out, bus, bus_idle;
  cpcd_byte_t exp_q[$];
  cpcd_row_t rows [NUM_ROWS];
  int n_fail, samples_checked, seed;

  // data wire: host, then device, else a pattern moving every cycle
  assign bus = drv_en ? drv : (!data_oe_n ? data_out : bus_idle);

  cpcd_decoder #(.DEVICE_ID(TB_ID)) dut (.mclk(mclk), .reset_n(reset_n), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .register_select_line(rs), .data_in(bus), .data_out(data_out), .data_oe_n(data_oe_n),
    .busy(busy));
  cpcd_host_model host (.mclk(mclk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .rs(rs), .drv(drv),
    .drv_en(drv_en));

  // clock
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // idle pattern and sticky busy flag
  always @(posedge mclk)
  begin
    bus_idle <= ~bus_idle;
    if (busy === 1'b1)
      busy_seen <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare tasks and verdict
  task automatic cmp8(input cpcd_byte_t got, input cpcd_byte_t exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask

  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // monitor: oldest note compared at the end of each read strobe
  always @(posedge rd_n)
  begin
    if (cs_n === 1'b0 && exp_q.size() > 0)
    begin
      cmp8(bus, exp_q.pop_front());
      cmp1(data_oe_n, 1'b0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // bus helpers
  function automatic cpcd_byte_t rchk(input cpcd_row_t r);
    return r[0] ^ r[1] ^ r[2] ^ r[3];
  endfunction

  task automatic rd(input logic sel, input cpcd_byte_t exp);
    exp_q.push_back(exp);
    host.access(1'b0, sel, 8'h00);
  endtask

  // write, then wait for busy to fall and check whether it rose
  task automatic dwr_sel(input logic sel, input cpcd_byte_t d, input logic exp_busy);
    int i;
    busy_seen = 1'b0;
    host.access(1'b1, sel, d);
    for (i = 0; i < 60 && busy !== 1'b0; i++)
      @(negedge mclk);
    cmp1(busy, 1'b0);
    cmp1(busy_seen, exp_busy);
    cmp1(data_oe_n, 1'b1);
  endtask

  task automatic dwr(input cpcd_byte_t d, input logic exp_busy);
    dwr_sel(1'b1, d, exp_busy);
  endtask

  // only defined codes, random upper bits
  task automatic cmd(input logic [CMD_W-1:0] c, input logic exp_busy);
    dwr_sel(1'b0, {4'($random(seed)), c}, exp_busy);
  endtask

  task automatic load_row(input logic [ROW_AW-1:0] a, input cpcd_row_t r, input cpcd_byte_t chk,
    input logic exp_busy, input cpcd_byte_t st);
    int b;
    cmd(CMD_LOAD_ROW, 1'b0);
    dwr({4'h0, a}, 1'b0);
    rd(1'b1, st);
    for (b = 0; b < ROW_BYTES; b++)
      dwr(r[b], 1'b0);
    dwr(chk, exp_busy);
  endtask

  task automatic read_row(input logic [ROW_AW-1:0] a, input cpcd_row_t r);
    int b;
    cmd(CMD_READ_ROW, 1'b0);
    dwr({4'h0, a}, 1'b1);
    for (b = 0; b < ROW_BYTES; b++)
      rd(1'b1, r[b]);
    rd(1'b1, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    int i;
    int b;
    seed = 90123;
    n_fail = 0;
    samples_checked = 0;
    busy_seen = 1'b0;
    bus_idle = 8'h3c;
    reset_n = 1'b0;
    repeat (10) @(negedge mclk);
    reset_n = 1'b1;
    for (i = 0; i < NUM_ROWS; i++)
      rows[i] = $random(seed);
    rd(1'b1, 8'h00);
    rd(1'b0, 8'h00);
    cmd(CMD_NOP, 1'b0);
    rd(1'b1, 8'h00);
    cmd(CMD_RESET_DEV, 1'b1);
    // partial row load cut short by the identifier command
    cmd(CMD_LOAD_ROW, 1'b0);
    dwr(8'h02, 1'b0);
    dwr(8'ha5, 1'b0);
    cmd(CMD_READ_ID, 1'b0);
    for (i = 0; i < ID_BYTES; i++)
      rd(1'b1, TB_ID[8*(3-i) +: 8]);
    rd(1'b1, 8'h00);
    load_row(4'h5, rows[5], rchk(rows[5]), 1'b1, 8'h00);
    read_row(4'h5, rows[5]);
    cmd(CMD_RESET_ROW, 1'b0);
    dwr(8'h05, 1'b1);
    read_row(4'h5, '0);
    // bad check byte, then the lock on data writes
    load_row(4'h6, rows[6], ~rchk(rows[6]), 1'b0, 8'h00);
    rd(1'b1, 8'h02);
    load_row(4'h6, rows[6], rchk(rows[6]), 1'b0, 8'h02);
    cmd(CMD_LOAD_CFG, 1'b0);
    dwr(~TB_ID[31:24], 1'b0);
    rd(1'b1, 8'h01);
    dwr(TB_ID[23:16], 1'b0);
    rd(1'b1, 8'h01);
    cmd(CMD_RESET_DEV, 1'b1);
    rd(1'b1, 8'h00);
    // full configuration load, header first
    cmd(CMD_LOAD_CFG, 1'b0);
    for (i = 0; i < ID_BYTES; i++)
      dwr(TB_ID[8*(3-i) +: 8], 1'b0);
    for (i = 0; i < NUM_ROWS; i++)
    begin
      for (b = 0; b < ROW_BYTES; b++)
        dwr(rows[i][b], 1'b0);
      dwr(rchk(rows[i]), 1'b1);
      rd(1'b1, 8'h00);
    end
    read_row(ROW_FIRST, rows[0]);
    read_row(ROW_LAST, rows[NUM_ROWS-1]);
    test_done();
  end

  // watchdog well beyond the expected run length
  initial
  begin
    #1000000;
    n_fail++;
    test_done();
  end
endmodule
`default_nettype wire
